// ==== verilog/irq_unit_defs.svh ====
// Constants for the two-source interrupt unit
`ifndef IRQ_UNIT_DEFS_SVH
`define IRQ_UNIT_DEFS_SVH
`define INTERRUPT_CONTROL_ADDR      7'h0b
`define BIT_GLOBAL_EN  0
`define BIT_EXT_EN     1
`define BIT_TIMER_EN   2
`define BIT_EXT_FLAG   4
`define BIT_TIMER_FLAG 5
`define INTERRUPT_CONTROL_RESET     8'h00
`define INTERRUPT_CONTROL_WMASK     8'h37
`define VEC_EXT        10'h004
`define VEC_TIMER      10'h008
`define STACK_LEVELS   4
`endif

// ==== verilog/irq_unit_pkg.sv ====
// Types for the two-source interrupt unit
package irq_unit_pkg;
   typedef struct packed {
      logic       req;
      logic [9:0] vector;
      logic       src_ext;
   } ack_t;
   typedef enum logic [1:0] {
      st_run  = 2'b01,
      st_halt = 2'b10
   } run_state_t;
endpackage

// ==== verilog/two_source_interrupt_unit.sv ====
// Interrupt control register, priority, vectoring and wake-up for two sources
//
// How it works
// - Falling edge on request pin sets bit 4
// - Enabled external request forces call to 04H
// - External acknowledge clears its flag and global
// - Timer overflow sets bit 5
// - Timer acknowledge calls 08H, clears flag, global
// - Full stack defers acknowledge until a return
// - Masked requests still latch flags, no call
// - Entry pushes only the program counter
// - Enabling return sets global; plain return not
// - Requests between phase-two pulses serviced next
// - External beats timer; global masks both
// - Service needs global and own enable
// - Flags hold until serviced or cleared
// - Bits 0,1,2 are global, external, timer enable
// - Bits 3,6,7 read as zero
// - Either request wakes from halt
// - Return stack holds four levels
// - Flag already set at halt: no wake
`timescale 1ns/100ps
`include "irq_unit_defs.svh"
module two_source_interrupt_unit #(
   parameter int STACK_DEPTH = `STACK_LEVELS
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Sources
   input  wire logic       ext_req_n,
   input  wire logic       timer_overflow,
   // Core data-memory access
   input  wire logic [6:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata_q,
   // Core sequencer
   input  wire logic       phase_two_clock,
   input  wire logic       call_push,
   input  wire logic       return_and_enable,
   input  wire logic       plain_return,
   input  wire logic       halt_enter,
   output logic            irq_call_q,
   output logic      [9:0] irq_vector_q,
   output logic            wake_q,
   output logic            stack_full_q
);
   ////////////////////////////////////////////////////////////////////////////
   logic       ext_pin_q;
   logic       glb_q;
   logic       ext_en_q;
   logic       tmr_en_q;
   logic       ext_flag_q;
   logic       tmr_flag_q;
   logic [2:0] level_q;
   logic       ext_wake_ok_q;
   logic       tmr_wake_ok_q;
   irq_unit_pkg::run_state_t state_q;
   irq_unit_pkg::ack_t       ack;

   wire ext_edge = ext_pin_q & ~ext_req_n;
   wire interrupt_control_wr  = reg_wr && (reg_addr == `INTERRUPT_CONTROL_ADDR);
   wire pop      = return_and_enable | plain_return;
   wire full     = (level_q == 3'(STACK_DEPTH));
   // Service point: one phase-two pulse; requests latched before it are taken
   wire ext_ok   = glb_q & ext_en_q & ext_flag_q;
   wire tmr_ok   = glb_q & tmr_en_q & tmr_flag_q;
   wire take     = phase_two_clock & ~full & ~irq_call_q & (ext_ok | tmr_ok);
   assign ack.req     = take;
   assign ack.src_ext = ext_ok;
   assign ack.vector  = ext_ok ? `VEC_EXT : `VEC_TIMER;
   wire take_ext = ack.req & ack.src_ext;
   wire take_tmr = ack.req & ~ack.src_ext;

   ////////////////////////////////////////////////////////////////////////////
   // Set wins over a software clear in the same cycle
   // Masked requests still latch here, so nothing is lost while the routine runs
   wire ext_flag_d = ext_edge | (take_ext ? 1'b0 :
                     interrupt_control_wr ? reg_wdata[`BIT_EXT_FLAG] : ext_flag_q);
   wire tmr_flag_d = timer_overflow | (take_tmr ? 1'b0 :
                     interrupt_control_wr ? reg_wdata[`BIT_TIMER_FLAG] : tmr_flag_q);
   wire glb_d      = take ? 1'b0 :
                     return_and_enable ? 1'b1 :
                     interrupt_control_wr ? reg_wdata[`BIT_GLOBAL_EN] : glb_q;
   wire [7:0] interrupt_control_view = {2'b00, tmr_flag_q, ext_flag_q, 1'b0,
                           tmr_en_q, ext_en_q, glb_q};
   // Only the return address level is tracked; status is not saved
   wire push = take | call_push;
   wire [2:0] level_d = (push && !pop && !full) ? level_q + 3'd1 :
                        (pop && !push && level_q != 3'd0) ? level_q - 3'd1 : level_q;
   wire wake_ev = (ext_edge & ext_wake_ok_q) | (timer_overflow & tmr_wake_ok_q);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_pin_q  <= 1'b1;
         glb_q      <= 1'b0;
         ext_en_q   <= 1'b0;
         tmr_en_q   <= 1'b0;
         ext_flag_q <= 1'b0;
         tmr_flag_q <= 1'b0;
         level_q    <= 3'd0;
      end else begin
         ext_pin_q  <= ext_req_n;
         glb_q      <= glb_d;
         ext_en_q   <= interrupt_control_wr ? reg_wdata[`BIT_EXT_EN] : ext_en_q;
         tmr_en_q   <= interrupt_control_wr ? reg_wdata[`BIT_TIMER_EN] : tmr_en_q;
         ext_flag_q <= ext_flag_d;
         tmr_flag_q <= tmr_flag_d;
         level_q    <= level_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_call_q   <= 1'b0;
         irq_vector_q <= 10'h000;
         reg_rdata_q  <= 8'h00;
         stack_full_q <= 1'b0;
      end else begin
         irq_call_q   <= take;
         irq_vector_q <= take ? ack.vector : irq_vector_q;
         reg_rdata_q  <= (reg_addr == `INTERRUPT_CONTROL_ADDR) ? interrupt_control_view : 8'h00;
         stack_full_q <= (level_d == 3'(STACK_DEPTH));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q       <= irq_unit_pkg::st_run;
         wake_q        <= 1'b0;
         ext_wake_ok_q <= 1'b0;
         tmr_wake_ok_q <= 1'b0;
      end else begin
         wake_q <= 1'b0;
         case (state_q)
            irq_unit_pkg::st_run: begin
               if (halt_enter) begin
                  state_q       <= irq_unit_pkg::st_halt;
                  ext_wake_ok_q <= ~ext_flag_q;
                  tmr_wake_ok_q <= ~tmr_flag_q;
               end
            end
            irq_unit_pkg::st_halt: begin
               if (wake_ev) begin
                  state_q <= irq_unit_pkg::st_run;
                  wake_q  <= 1'b1;
               end
            end
            default: state_q <= irq_unit_pkg::st_run;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_ext_take;
      take_ext;
   endsequence
   sequence s_call_ext;
      irq_call_q && irq_vector_q == `VEC_EXT;
   endsequence

   // Both pending at one service point: external goes, timer stays pending
   sequence s_both_take;
      take && ext_ok && tmr_ok && !interrupt_control_wr;
   endsequence
   sequence s_tmr_waits;
      tmr_flag_q;
   endsequence

   a_ext_edge_flag: assert property (@(posedge clk) disable iff (!nrst)
      ext_edge |=> ext_flag_q)
      else $error("external edge did not set flag");

   a_ext_vector: assert property (@(posedge clk) disable iff (!nrst)
      s_ext_take |=> s_call_ext)
      else $error("external vector wrong");

   a_ext_clear: assert property (@(posedge clk) disable iff (!nrst)
      take_ext && !ext_edge && !return_and_enable |=> !glb_q && !ext_flag_q)
      else $error("external acknowledge did not clear");

   a_tmr_flag: assert property (@(posedge clk) disable iff (!nrst)
      timer_overflow |=> tmr_flag_q)
      else $error("overflow did not set flag");

   a_tmr_vector: assert property (@(posedge clk) disable iff (!nrst)
      take_tmr |=> irq_call_q && irq_vector_q == `VEC_TIMER)
      else $error("timer vector wrong");

   a_full_hold: assert property (@(posedge clk) disable iff (!nrst)
      full |-> !take)
      else $error("acknowledge with full stack");

   a_masked_none: assert property (@(posedge clk) disable iff (!nrst)
      !glb_q |=> !irq_call_q)
      else $error("call while globally masked");

   a_return_and_enable_sets: assert property (@(posedge clk) disable iff (!nrst)
      return_and_enable && !take |=> glb_q)
      else $error("enabling return did not set global");

   a_priority: assert property (@(posedge clk) disable iff (!nrst)
      take && ext_ok |-> ack.vector == `VEC_EXT)
      else $error("priority wrong");

   a_zero_bits: assert property (@(posedge clk) disable iff (!nrst)
      reg_rdata_q[3] == 1'b0 && reg_rdata_q[7:6] == 2'b00)
      else $error("unused bits nonzero");

   a_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
      ext_flag_q && !take_ext && !interrupt_control_wr |=> ext_flag_q)
      else $error("flag dropped");

   a_tmr_clear: assert property (@(posedge clk) disable iff (!nrst)
      take_tmr && !timer_overflow && !return_and_enable |=> !glb_q && !tmr_flag_q)
      else $error("timer acknowledge did not clear");

   a_tmr_hold: assert property (@(posedge clk) disable iff (!nrst)
      tmr_flag_q && !take_tmr && !interrupt_control_wr |=> tmr_flag_q)
      else $error("timer flag dropped");

   a_masked_latch: assert property (@(posedge clk) disable iff (!nrst)
      !glb_q && ext_edge |=> ext_flag_q && !irq_call_q)
      else $error("masked request not latched");

   a_both_pri: assert property (@(posedge clk) disable iff (!nrst)
      s_both_take |=> s_call_ext ##0 s_tmr_waits)
      else $error("simultaneous requests mishandled");

   a_take_enabled: assert property (@(posedge clk) disable iff (!nrst)
      take |-> glb_q && ((ext_en_q && ext_flag_q) || (tmr_en_q && tmr_flag_q)))
      else $error("service without enables");

   a_call_p2: assert property (@(posedge clk) disable iff (!nrst)
      irq_call_q |-> $past(phase_two_clock))
      else $error("call away from service point");

   a_call_one: assert property (@(posedge clk) disable iff (!nrst)
      irq_call_q |=> !irq_call_q)
      else $error("call pulse too long");

   a_no_busy_take: assert property (@(posedge clk) disable iff (!nrst)
      irq_call_q |-> !take)
      else $error("back-to-back acknowledge");

   a_vector_hold: assert property (@(posedge clk) disable iff (!nrst)
      !irq_call_q |-> $stable(irq_vector_q))
      else $error("vector moved without call");

   // A deferred request must survive until a return frees a level
   a_stack_defer: assert property (@(posedge clk) disable iff (!nrst)
      full && (ext_ok || tmr_ok) && !interrupt_control_wr |=> ext_flag_q || tmr_flag_q)
      else $error("deferred request lost");

   a_plain_ret: assert property (@(posedge clk) disable iff (!nrst)
      plain_return && !return_and_enable && !take && !interrupt_control_wr |=> glb_q == $past(glb_q))
      else $error("plain return changed global");

   a_push_level: assert property (@(posedge clk) disable iff (!nrst)
      take && !pop |=> level_q == $past(level_q) + 3'd1)
      else $error("entry did not push");

   a_pop_level: assert property (@(posedge clk) disable iff (!nrst)
      pop && !push && level_q != 3'd0 |=> level_q == $past(level_q) - 3'd1)
      else $error("return did not pop");

   a_level_max: assert property (@(posedge clk) disable iff (!nrst)
      level_q <= 3'(STACK_DEPTH))
      else $error("stack level overrun");

   a_full_out: assert property (@(posedge clk) disable iff (!nrst)
      stack_full_q == full)
      else $error("full output wrong");

   a_ext_wake: assert property (@(posedge clk) disable iff (!nrst)
      state_q == irq_unit_pkg::st_halt && ext_edge && ext_wake_ok_q |=> wake_q)
      else $error("external request did not wake");

   a_tmr_wake: assert property (@(posedge clk) disable iff (!nrst)
      state_q == irq_unit_pkg::st_halt && timer_overflow && tmr_wake_ok_q |=> wake_q)
      else $error("overflow did not wake");

   a_wake_one: assert property (@(posedge clk) disable iff (!nrst)
      wake_q |=> !wake_q)
      else $error("wake pulse too long");

   // Wake must come only from an armed source
   a_wake_src: assert property (@(posedge clk) disable iff (!nrst)
      state_q == irq_unit_pkg::st_halt && !(ext_edge && ext_wake_ok_q)
      && !(timer_overflow && tmr_wake_ok_q) |=> !wake_q)
      else $error("wake without armed source");

   a_ext_arm: assert property (@(posedge clk) disable iff (!nrst)
      state_q == irq_unit_pkg::st_run && halt_enter && ext_flag_q |=> !ext_wake_ok_q)
      else $error("external wake armed with flag set");

   a_tmr_arm: assert property (@(posedge clk) disable iff (!nrst)
      state_q == irq_unit_pkg::st_run && halt_enter && tmr_flag_q |=> !tmr_wake_ok_q)
      else $error("timer wake armed with flag set");
endmodule

// ==== tb/core_seq_model.sv ====
// Core sequencer model: one service-point pulse every fourth clock
`timescale 1ns/100ps
module core_seq_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Service point
   output logic      phase_two_clock
);
   logic [1:0] div_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) div_q <= 2'h0;
      else div_q <= div_q + 2'h1;
   end
   assign phase_two_clock = (div_q == 2'h3);
endmodule

// ==== tb/two_source_interrupt_unit_tb.sv ====
// Self-checking bench for the two-source interrupt unit
`timescale 1ns/100ps
`include "irq_unit_defs.svh"
module two_source_interrupt_unit_tb;
   logic clk = 0, nrst = 0, ext_req_n = 1, reg_wr = 0, p2, call_q, wake, full;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, rdata;
   logic [4:0] ev = 5'h00;
   logic [9:0] vec;
   logic [9:0] exp_q[$];
   int n_errors = 0, check_count = 0, i, k;
   initial forever #4 clk = ~clk;
   core_seq_model u_core (.clk(clk), .nrst(nrst), .phase_two_clock(p2));
   two_source_interrupt_unit u_dut (.clk(clk), .nrst(nrst), .ext_req_n(ext_req_n),
      .timer_overflow(ev[4]), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata_q(rdata), .phase_two_clock(p2), .call_push(ev[0]),
      .return_and_enable(ev[2]), .plain_return(ev[1]), .halt_enter(ev[3]),
      .irq_call_q(call_q), .irq_vector_q(vec), .wake_q(wake), .stack_full_q(full));
   task chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin n_errors++; $display("BAD %0t %s", $time, m); end
   endtask
   task tally_and_finish;
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task wr(input logic [7:0] d);
      @(posedge clk) begin reg_wr <= 1; reg_addr <= `INTERRUPT_CONTROL_ADDR; reg_wdata <= d; end
      @(posedge clk) reg_wr <= 0;
   endtask
   task rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk) reg_addr <= a;
      @(posedge clk) #1;
      chk(rdata === e, "read data");
   endtask
   task pulse(input logic [4:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 5'h00;
   endtask
   task ext_fall;
      repeat ($urandom_range(1, 5)) @(posedge clk);
      ext_req_n <= 0;
      repeat (2) @(posedge clk);
      ext_req_n <= 1;
   endtask
   task wait_q;
      for (k = 0; k < 40 && exp_q.size() != 0; k++) @(posedge clk);
      chk(exp_q.size() == 0, "call missing");
   endtask
   // Every forced call must match the oldest expected vector
   always @(posedge clk) if (nrst === 1'b1 && call_q === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected call");
      else chk(vec === exp_q.pop_front(), "vector");
   end
   initial begin
      #40000;
      chk(1'b0, "timeout");
      tally_and_finish;
   end
   initial begin
      void'($urandom(90));
      repeat (12) @(posedge clk);
      nrst <= 1;
      rd(`INTERRUPT_CONTROL_ADDR, 8'h00);
      rd(7'($urandom_range(12, 127)), 8'h00);
      wr(8'hcf);
      rd(`INTERRUPT_CONTROL_ADDR, 8'h07);
      exp_q.push_back(`VEC_EXT);
      ext_fall;
      wait_q;
      rd(`INTERRUPT_CONTROL_ADDR, 8'h06);
      ext_fall;
      pulse(5'h10);
      repeat (10) @(posedge clk);
      rd(`INTERRUPT_CONTROL_ADDR, 8'h36);
      exp_q.push_back(`VEC_EXT);
      wr(8'h37);
      wait_q;
      rd(`INTERRUPT_CONTROL_ADDR, 8'h26);
      exp_q.push_back(`VEC_TIMER);
      wr(8'h27);
      wait_q;
      rd(`INTERRUPT_CONTROL_ADDR, 8'h06);
      pulse(5'h01);
      @(posedge clk) #1;
      chk(full === 1'b1, "stack full");
      wr(8'h07);
      pulse(5'h10);
      repeat (10) @(posedge clk);
      rd(`INTERRUPT_CONTROL_ADDR, 8'h27);
      exp_q.push_back(`VEC_TIMER);
      pulse(5'h02);
      wait_q;
      pulse(5'h04);
      rd(`INTERRUPT_CONTROL_ADDR, 8'h07);
      wr(8'h00);
      for (i = 0; i < 2; i++) begin
         pulse(5'h08);
         pulse(5'h10);
         #1;
         for (k = 0; k < 10 && wake !== 1'b1; k++) @(posedge clk) #1;
         chk((k < 10) == (i == 0), "wake");
      end
      tally_and_finish;
   end
endmodule
